/* File: inc/pin_config_pkg.sv */
// Purpose: Shared constants for the pin four to six configuration block
// Assumes: 250 MHz core clock
// Notes: Register offsets, field positions, function codes and timing
package pin_config_pkg;

	// Register offsets on the internal register port
	localparam logic [7:0] PIN_FOUR_CONFIG_ADDR = 8'h34;
	localparam logic [7:0] PIN_FIVE_CONFIG_ADDR = 8'h35;
	localparam logic [7:0] PIN_SIX_CONFIG_ADDR = 8'h36;

	// Value after reset, before the non-volatile defaults arrive
	localparam logic [7:0] PIN_CONFIG_RESET = 8'h0a;

	// Field positions inside each configuration byte
	localparam int FUNC_MSB = 7;
	localparam int FUNC_LSB = 5;
	localparam int FILTER_ON_BIT = 4;
	localparam int PULL_ON_BIT = 3;
	localparam int PULL_POLARITY_BIT = 2;
	localparam int DRIVE_TYPE_BIT = 1;
	localparam int DIRECTION_BIT = 0;

	// Function codes shared by all three pins
	localparam logic [2:0] FUNC_PLAIN = 3'h0;
	localparam logic [2:0] FUNC_SLEEP_ONE = 3'h4;
	localparam logic [2:0] FUNC_SLEEP_TWO = 3'h5;
	localparam logic [2:0] FUNC_WAKE_ONE = 3'h6;
	localparam logic [2:0] FUNC_WAKE_TWO = 3'h7;

	// Pin four function codes
	localparam logic [2:0] FOUR_ENABLE = 3'h1;
	localparam logic [2:0] FOUR_WATCHDOG = 3'h2;
	localparam logic [2:0] FOUR_BUCK_MONITOR = 3'h3;

	// Pin five function codes
	localparam logic [2:0] FIVE_SYNC_IN = 3'h1;
	localparam logic [2:0] FIVE_SYNC_OUT = 3'h2;
	localparam logic [2:0] FIVE_RESET_OUT = 3'h3;

	// Pin six function codes
	localparam logic [2:0] SIX_ERROR_IN = 3'h1;
	localparam logic [2:0] SIX_SYNC_OUT = 3'h2;
	localparam logic [2:0] SIX_POWER_GOOD = 3'h3;

	// Deglitch timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int DEGLITCH_TIME_US = 8;
	localparam int DEGLITCH_CYCLES = (DEGLITCH_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int DEGLITCH_COUNT_W = $clog2(DEGLITCH_CYCLES + 1);

endpackage : pin_config_pkg

/* File: logic/pin_deglitch.sv */
// Purpose: Synchronise one pin input and optionally deglitch it
// Assumes: Pin level may change at any time relative to clk
// Notes: Filter length counted in core clock cycles
module pin_deglitch
	import pin_config_pkg::*;
#(
	parameter int COUNT_W = DEGLITCH_COUNT_W,
	parameter int STABLE_CYCLES = DEGLITCH_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin_level,
	input wire logic filter_on,
	output logic level
);

	localparam logic [COUNT_W-1:0] LAST_COUNT = COUNT_W'(STABLE_CYCLES - 1);

	logic sync_first;
	logic sync_second;
	logic [COUNT_W-1:0] count;
	wire differs = sync_second != level;
	wire expired = count == LAST_COUNT;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_first <= 1'b0;
			sync_second <= 1'b0;
		end else begin
			sync_first <= pin_level;
			sync_second <= sync_first;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level <= 1'b0;
			count <= '0;
		end else if (!filter_on) begin
			level <= sync_second;
			count <= '0;
		end else if (!differs) begin
			count <= '0;
		end else if (expired) begin
			level <= sync_second;
			count <= '0;
		end else begin
			count <= count + COUNT_W'(1);
		end
	end

endmodule : pin_deglitch

/* File: logic/pin_pad_control.sv */
// Purpose: Turn one configuration byte into pad drive and pull controls
// Assumes: Pad resolves output, enable and pull into the wire level
// Notes: All pad controls registered
module pin_pad_control
	import pin_config_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] config_byte,
	input wire logic out_value,
	output logic pad_out,
	output logic pad_oe,
	output logic pull_up_on,
	output logic pull_down_on
);

	wire is_output = config_byte[DIRECTION_BIT];
	wire open_drain = config_byte[DRIVE_TYPE_BIT];
	wire pull_on = config_byte[PULL_ON_BIT];
	wire pull_up_sel = config_byte[PULL_POLARITY_BIT];
	wire next_pad_out = open_drain ? 1'b0 : out_value;
	wire next_pad_oe = is_output & (open_drain ? ~out_value : 1'b1);
	wire next_pull_up = pull_on & pull_up_sel;
	wire next_pull_down = pull_on & ~pull_up_sel;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			pull_up_on <= 1'b0;
			pull_down_on <= 1'b0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
			pull_up_on <= next_pull_up;
			pull_down_on <= next_pull_down;
		end
	end

endmodule : pin_pad_control

/* File: logic/pin_config_four_to_six.sv */
// Purpose: Configuration registers and function routing for pins four to six
// Assumes: Register port synchronous to clk; pins synchronised inside; nvm_load from loader
// Notes: Index 0, 1, 2 of pin vectors are pins four, five, six
//
// Overview of operation
// - Pin four bits 7:5 choose plain, enable, watchdog, monitor, sleep or wake.
// - Pin four code 3 moves buck one monitor input onto pin four.
// - Pin five bits 7:5 choose plain, sync in, sync out, reset out, sleep, wake.
// - Pin six bits 7:5 choose plain, error in, sync out, power good, sleep, wake.
// - Input bit 4 clear only synchronises; set adds an 8 us deglitch.
// - Bit 3 set connects the pull resistor; clear disconnects it.
// - Pull polarity bit 2 only matters while bit 3 is set.
// - Polarity clear selects pull down; set selects pull up.
// - Output bit 1 clear drives push pull; set drives open drain low only.
// - Bit 0 clear makes the pin an input; set makes it an output.
// - Registers reset to 0x0a; real defaults come from non-volatile memory.
module pin_config_four_to_six
	import pin_config_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic nvm_load,
	input wire logic [7:0] nvm_pin_four,
	input wire logic [7:0] nvm_pin_five,
	input wire logic [7:0] nvm_pin_six,
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	output logic [2:0] pin_pull_up,
	output logic [2:0] pin_pull_down,
	input wire logic [2:0] plain_out_level,
	output logic [2:0] plain_in_level,
	input wire logic sync_clock_source,
	input wire logic processor_reset_level,
	input wire logic power_good_level,
	output logic enable_input,
	output logic watchdog_trigger_input,
	output logic buck_one_monitor_from_pin,
	output logic sync_clock_input,
	output logic controller_error_input_n,
	output logic sleep_request_one_n,
	output logic sleep_request_two_n,
	output logic wake_input_one,
	output logic wake_input_two
);

	logic [7:0] pin_four_config;
	logic [7:0] pin_five_config;
	logic [7:0] pin_six_config;
	logic [2:0] filtered;

	// Picks the level of the lowest pin carrying a function, else idle value
	function automatic logic route_level(input logic [2:0] sel_hit, input logic [2:0] lvl,
		input logic idle);
		logic result;
		result = idle;
		if (sel_hit[0]) begin
			result = lvl[0];
		end else if (sel_hit[1]) begin
			result = lvl[1];
		end else if (sel_hit[2]) begin
			result = lvl[2];
		end
		return result;
	endfunction : route_level

	// Loader wins over a register write landing in the same cycle
	function automatic logic [7:0] next_config(input logic load, input logic [7:0] nvm_value,
		input logic write, input logic [7:0] wdata, input logic [7:0] current);
		logic [7:0] result;
		result = current;
		if (load) begin
			result = nvm_value;
		end else if (write) begin
			result = wdata;
		end
		return result;
	endfunction : next_config

	// Unmapped addresses read back as zero
	function automatic logic [7:0] read_select(input logic [2:0] hit, input logic [7:0] four,
		input logic [7:0] five, input logic [7:0] six);
		logic [7:0] result;
		result = 8'h00;
		if (hit[0]) begin
			result = four;
		end else if (hit[1]) begin
			result = five;
		end else if (hit[2]) begin
			result = six;
		end
		return result;
	endfunction : read_select

	// Output source of a pin: sync clock, its own status line, or the plain level
	function automatic logic drive_value(input logic sync_out, input logic status_out,
		input logic sync_level, input logic status_level, input logic plain_level);
		logic result;
		result = plain_level;
		if (sync_out) begin
			result = sync_level;
		end else if (status_out) begin
			result = status_level;
		end
		return result;
	endfunction : drive_value

	// Register port decode
	wire hit_four = reg_addr == PIN_FOUR_CONFIG_ADDR;
	wire hit_five = reg_addr == PIN_FIVE_CONFIG_ADDR;
	wire hit_six = reg_addr == PIN_SIX_CONFIG_ADDR;
	wire write_four = reg_write & hit_four;
	wire write_five = reg_write & hit_five;
	wire write_six = reg_write & hit_six;

	// A read in the cycle of a write returns the value before the write
	wire [7:0] next_rdata = read_select({hit_six, hit_five, hit_four}, pin_four_config,
		pin_five_config, pin_six_config);

	wire [7:0] next_four_config = next_config(nvm_load, nvm_pin_four, write_four, reg_wdata,
		pin_four_config);
	wire [7:0] next_five_config = next_config(nvm_load, nvm_pin_five, write_five, reg_wdata,
		pin_five_config);
	wire [7:0] next_six_config = next_config(nvm_load, nvm_pin_six, write_six, reg_wdata,
		pin_six_config);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_four_config <= PIN_CONFIG_RESET;
		end else begin
			pin_four_config <= next_four_config;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_five_config <= PIN_CONFIG_RESET;
		end else begin
			pin_five_config <= next_five_config;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_six_config <= PIN_CONFIG_RESET;
		end else begin
			pin_six_config <= next_six_config;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// Field extraction
	wire [2:0] four_func = pin_four_config[FUNC_MSB:FUNC_LSB];
	wire [2:0] five_func = pin_five_config[FUNC_MSB:FUNC_LSB];
	wire [2:0] six_func = pin_six_config[FUNC_MSB:FUNC_LSB];
	wire [2:0] filter_on = {pin_six_config[FILTER_ON_BIT], pin_five_config[FILTER_ON_BIT],
		pin_four_config[FILTER_ON_BIT]};
	wire [2:0] is_input = ~{pin_six_config[DIRECTION_BIT], pin_five_config[DIRECTION_BIT],
		pin_four_config[DIRECTION_BIT]};

	wire four_enable = four_func == FOUR_ENABLE;
	wire four_watchdog = four_func == FOUR_WATCHDOG;
	wire four_monitor = four_func == FOUR_BUCK_MONITOR;
	wire five_sync_in = five_func == FIVE_SYNC_IN;
	wire five_sync_out = five_func == FIVE_SYNC_OUT;
	wire five_reset_out = five_func == FIVE_RESET_OUT;
	wire six_error_in = six_func == SIX_ERROR_IN;
	wire six_sync_out = six_func == SIX_SYNC_OUT;
	wire six_power_good = six_func == SIX_POWER_GOOD;

	// Shared sleep and wake codes on all three pins
	wire [2:0] sel_sleep_one = {six_func == FUNC_SLEEP_ONE, five_func == FUNC_SLEEP_ONE,
		four_func == FUNC_SLEEP_ONE};
	wire [2:0] sel_sleep_two = {six_func == FUNC_SLEEP_TWO, five_func == FUNC_SLEEP_TWO,
		four_func == FUNC_SLEEP_TWO};
	wire [2:0] sel_wake_one = {six_func == FUNC_WAKE_ONE, five_func == FUNC_WAKE_ONE,
		four_func == FUNC_WAKE_ONE};
	wire [2:0] sel_wake_two = {six_func == FUNC_WAKE_TWO, five_func == FUNC_WAKE_TWO,
		four_func == FUNC_WAKE_TWO};
	wire [2:0] sel_plain = {six_func == FUNC_PLAIN, five_func == FUNC_PLAIN,
		four_func == FUNC_PLAIN};

	// Only input pins feed internal functions
	wire [2:0] in_lvl = filtered;
	wire [2:0] inp = is_input;

	wire next_enable = inp[0] & four_enable & in_lvl[0];
	wire next_watchdog = inp[0] & four_watchdog & in_lvl[0];
	wire next_sync_in = inp[1] & five_sync_in & in_lvl[1];
	wire next_error_n = (inp[2] & six_error_in) ? in_lvl[2] : 1'b1;
	wire next_sleep_one_n = route_level(sel_sleep_one & inp, in_lvl, 1'b1);
	wire next_sleep_two_n = route_level(sel_sleep_two & inp, in_lvl, 1'b1);
	wire next_wake_one = route_level(sel_wake_one & inp, in_lvl, 1'b0);
	wire next_wake_two = route_level(sel_wake_two & inp, in_lvl, 1'b0);
	wire [2:0] next_plain_in = sel_plain & inp & in_lvl;

	// Output value per pin by function
	wire four_value = plain_out_level[0];
	wire five_value = drive_value(five_sync_out, five_reset_out, sync_clock_source,
		processor_reset_level, plain_out_level[1]);
	wire six_value = drive_value(six_sync_out, six_power_good, sync_clock_source,
		power_good_level, plain_out_level[2]);
	wire [2:0] out_value = {six_value, five_value, four_value};
	wire [2:0][7:0] configs = {pin_six_config, pin_five_config, pin_four_config};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_input <= 1'b0;
			watchdog_trigger_input <= 1'b0;
		end else begin
			enable_input <= next_enable;
			watchdog_trigger_input <= next_watchdog;
		end
	end

	// monitor source select
	// Follows the code alone, as the analog monitor path has no direction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			buck_one_monitor_from_pin <= 1'b0;
		end else begin
			buck_one_monitor_from_pin <= four_monitor;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_clock_input <= 1'b0;
			controller_error_input_n <= 1'b1;
		end else begin
			sync_clock_input <= next_sync_in;
			controller_error_input_n <= next_error_n;
		end
	end

	// Sleep requests idle high while no pin carries them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep_request_one_n <= 1'b1;
			sleep_request_two_n <= 1'b1;
		end else begin
			sleep_request_one_n <= next_sleep_one_n;
			sleep_request_two_n <= next_sleep_two_n;
		end
	end

	// Wake requests idle low while no pin carries them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wake_input_one <= 1'b0;
			wake_input_two <= 1'b0;
		end else begin
			wake_input_one <= next_wake_one;
			wake_input_two <= next_wake_two;
		end
	end

	// Plain input pins report their filtered level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			plain_in_level <= 3'h0;
		end else begin
			plain_in_level <= next_plain_in;
		end
	end

	// One input filter and one pad driver per pin

	for (genvar i = 0; i < 3; i++) begin : g_pin
		pin_deglitch u_filter (
			.clk(clk),
			.rstn(rstn),
			.pin_level(pin_in[i]),
			.filter_on(filter_on[i]),
			.level(filtered[i])
		);

		pin_pad_control u_pad (
			.clk(clk),
			.rstn(rstn),
			.config_byte(configs[i]),
			.out_value(out_value[i]),
			.pad_out(pin_out[i]),
			.pad_oe(pin_oe[i]),
			.pull_up_on(pin_pull_up[i]),
			.pull_down_on(pin_pull_down[i])
		);
	end

endmodule : pin_config_four_to_six

/* File: verif/pin_config_four_to_six_checker.sv */
// Purpose: Timing checks on the pin four to six configuration block
// Assumes: Pad controls follow a register write by two edges
// Notes: Pin four pads are watched; pins five and six share the logic
module pin_config_four_to_six_checker
	import pin_config_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic nvm_load,
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] pin_pull_up,
	input wire logic [2:0] pin_pull_down,
	input wire logic buck_one_monitor_from_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire w4 = reg_write && !nvm_load && reg_addr == PIN_FOUR_CONFIG_ADDR;
	wire calm = !reg_write && !nvm_load;
	property p_readback;
		w4 ##1 reg_read && reg_addr == 8'h34 |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("read data wrong");
	property p_pull_off;
		w4 && !reg_wdata[3] ##1 calm |=> !pin_pull_up[0] && !pin_pull_down[0];
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull not off");
	property p_pull_up;
		w4 && reg_wdata[3:2] == 2'h3 ##1 calm |=> pin_pull_up[0] && !pin_pull_down[0];
	endproperty
	a_pull_up: assert property (p_pull_up) else $error("pull up wrong");
	property p_input;
		w4 && !reg_wdata[0] ##1 calm |=> !pin_oe[0];
	endproperty
	a_input: assert property (p_input) else $error("input pin driven");
	property p_push;
		w4 && reg_wdata[1:0] == 2'h1 ##1 calm |=> pin_oe[0];
	endproperty
	a_push: assert property (p_push) else $error("push pull not driving");
	property p_open;
		w4 && reg_wdata[1:0] == 2'h3 ##1 calm |=> !pin_out[0];
	endproperty
	a_open: assert property (p_open) else $error("open drain drives high");
	property p_monitor;
		w4 && reg_wdata[7:5] == 3'h3 ##1 calm |=> buck_one_monitor_from_pin;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor not moved");
	property p_reset;
		$rose(rstn) && calm |=> pin_pull_down == 3'h7 && pin_oe == 3'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("pads not at reset");
	c_open: cover property (w4 && reg_wdata[1:0] == 2'h3);
	c_monitor: cover property ($rose(buck_one_monitor_from_pin));
	c_read: cover property (reg_read && reg_addr == 8'h34);
endmodule : pin_config_four_to_six_checker

bind pin_config_four_to_six pin_config_four_to_six_checker chk (.clk, .rstn, .reg_addr,
	.reg_write, .reg_read, .reg_wdata, .reg_rdata, .nvm_load, .pin_out, .pin_oe,
	.pin_pull_up, .pin_pull_down, .buck_one_monitor_from_pin);

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for pin four to six configuration
// Assumes: Pad controls settle two edges after a write
// Notes: Deglitch runs at its full 2000 cycles
module tb_top import pin_config_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, reg_write, reg_read, nvm_load, sync_clock_source;
	logic processor_reset_level, power_good_level;
	logic [7:0] reg_addr, reg_wdata, nvm_pin_four, nvm_pin_five, nvm_pin_six;
	logic [2:0] pin_in, plain_out_level;
	wire [7:0] reg_rdata;
	wire [2:0] pin_out, pin_oe, pin_pull_up, pin_pull_down, plain_in_level;
	wire enable_input, watchdog_trigger_input, buck_one_monitor_from_pin, sync_clock_input;
	wire controller_error_input_n, sleep_request_one_n, sleep_request_two_n;
	wire wake_input_one, wake_input_two;
	wire [7:0] routed = {enable_input, watchdog_trigger_input, buck_one_monitor_from_pin,
		sleep_request_one_n, sleep_request_two_n, wake_input_one, wake_input_two,
		plain_in_level[0]};
	int mismatches, checks;
	logic [15:0] pads [8] = '{16'h0010, 16'h0410, 16'h0814, 16'h0c18, 16'h0113, 16'h0310,
		16'h0302, 16'h0d0a};
	pin_config_four_to_six uut (.clk, .rstn, .reg_addr, .reg_write, .reg_read, .reg_wdata,
		.reg_rdata, .nvm_load, .nvm_pin_four, .nvm_pin_five, .nvm_pin_six, .pin_in, .pin_out,
		.pin_oe, .pin_pull_up, .pin_pull_down, .plain_out_level, .plain_in_level,
		.sync_clock_source, .processor_reset_level, .power_good_level, .enable_input,
		.watchdog_trigger_input, .buck_one_monitor_from_pin, .sync_clock_input,
		.controller_error_input_n, .sleep_request_one_n, .sleep_request_two_n,
		.wake_input_one, .wake_input_two);
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge clk);
		reg_write <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask : rd
	task automatic t_reset();
		for (int i = 0; i < 3; i++)
			rd(8'(8'h34 + i), 8'h0a);
		rd(8'h37, 8'h00);
		cmp({2'h0, pin_pull_up, pin_pull_down}, 8'h07);
		$display("reset done");
	endtask : t_reset
	task automatic t_nvm();
		@(posedge clk);
		{reg_addr, reg_wdata, reg_write} <= {16'h345a, 1'b1};
		@(posedge clk);
		{reg_write, reg_read} <= 2'h1;
		@(posedge clk);
		{nvm_pin_four, nvm_pin_five, nvm_pin_six} <= 24'h2142c4;
		{reg_wdata, reg_write, nvm_load, reg_read} <= {8'hff, 3'h6};
		#1;
		cmp(reg_rdata, 8'h5a);
		@(posedge clk);
		{nvm_load, reg_write} <= 2'h0;
		rd(PIN_FOUR_CONFIG_ADDR, 8'h21);
		rd(PIN_FIVE_CONFIG_ADDR, 8'h42);
		rd(PIN_SIX_CONFIG_ADDR, 8'hc4);
		$display("nvm done");
	endtask : t_nvm
	task automatic t_pads();
		for (int p = 0; p < 3; p++) begin
			foreach (pads[i]) begin
				@(posedge clk) plain_out_level <= {3{pads[i][4]}};
				wr(8'(8'h34 + p), pads[i][15:8]);
				cmp({pin_pull_up[p], pin_pull_down[p], pin_oe[p], pin_out[p] & pin_oe[p]},
					{4'h0, pads[i][3:0]});
			end
		end
		$display("pads done");
	endtask : t_pads
	task automatic t_inputs();
		for (int c = 0; c < 8; c++) begin
			wr(PIN_FOUR_CONFIG_ADDR, {c[2:0], 5'h00});
			for (int v = 0; v < 2; v++) begin
				@(posedge clk) pin_in <= {2'h0, v[0]};
				tick(6);
				cmp(routed, {c == 1 && v, c == 2 && v, c == 3, c == 4 ? v[0] : 1'b1,
					c == 5 ? v[0] : 1'b1, c == 6 && v, c == 7 && v, c == 0 && v});
			end
		end
		wr(PIN_FIVE_CONFIG_ADDR, 8'h20);
		wr(PIN_SIX_CONFIG_ADDR, 8'h20);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk) pin_in <= {v[0], v[0], 1'b0};
			tick(6);
			cmp({sync_clock_input, controller_error_input_n}, {2{v[0]}});
		end
		wr(PIN_FIVE_CONFIG_ADDR, 8'h80);
		wr(PIN_SIX_CONFIG_ADDR, 8'h00);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk) pin_in <= {v[0], !v[0], 1'b0};
			tick(6);
			cmp({sleep_request_one_n, plain_in_level}, {!v[0], v[0], 2'h0});
		end
		$display("inputs done");
	endtask : t_inputs
	task automatic t_outputs();
		for (int k = 0; k < 4; k++) begin
			wr(8'(8'h35 + k[1]), k[0] ? 8'h61 : 8'h41);
			for (int v = 0; v < 4; v++) begin
				@(posedge clk);
				{sync_clock_source, processor_reset_level, power_good_level} <= {v[0], v[1], !v[0]};
				tick(3);
				cmp({pin_oe[1 + k[1]], pin_out[1 + k[1]]},
					{1'b1, k == 1 ? v[1] : (k == 3 ? !v[0] : v[0])});
			end
		end
		$display("outputs done");
	endtask : t_outputs
	task automatic t_filter();
		wr(PIN_FOUR_CONFIG_ADDR, 8'h30);
		@(posedge clk) pin_in <= 3'h1;
		tick(DEGLITCH_CYCLES - 10);
		cmp(enable_input, 8'h00);
		@(posedge clk) pin_in <= 3'h0;
		tick(4);
		@(posedge clk) pin_in <= 3'h1;
		tick(DEGLITCH_CYCLES - 10);
		cmp(enable_input, 8'h00);
		tick(20);
		cmp(enable_input, 8'h01);
		$display("filter done");
	endtask : t_filter
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rstn, reg_write, reg_read, nvm_load, reg_addr, reg_wdata} = '0;
		{nvm_pin_four, nvm_pin_five, nvm_pin_six, pin_in, plain_out_level} = '0;
		{sync_clock_source, processor_reset_level, power_good_level} = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_nvm();
		t_pads();
		t_inputs();
		t_outputs();
		t_filter();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
endmodule : tb_top
